// file: hw/rtts_retire_tagging.sv
`timescale 1ns/1ps
`default_nettype none
module rtts_retire_tagging #(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
) (
  // clock, reset, enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // operation seen upstream, where tags are set
  input  wire logic             up_valid,
  input  wire logic [IDX_W-1:0] up_idx,
  input  wire logic             up_is_load,
  input  wire logic             up_is_store,
  input  wire logic             up_is_branch,
  input  wire logic [2:0]       up_class,
  input  wire logic             up_untaggable,
  input  wire logic             up_l1_miss,
  input  wire logic             up_l2_fast_miss,
  input  wire logic             up_dtlb_miss,
  input  wire logic             up_split,
  input  wire logic             up_fwd_not_subset,
  input  wire logic             up_mispred,
  input  wire logic             fp_stack_fault,
  // retirement
  input  wire logic             ret_valid,
  input  wire logic [IDX_W-1:0] ret_idx,
  input  wire logic             ret_bogus
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic [31:0] uop_sel_q, exec_sel_q, moves_sel_q, sample_en_q;
  logic [31:0] matrix_q, xlate_one_q, xlate_zero_q, mob_sel_q;
  logic [31:0] retire_sel_q;
  logic [31:0] cnt_q [rtts_pkg::NUM_PATHS];

  // refuse slot counts that the index cannot address
  if (DEPTH > (1 << IDX_W) || DEPTH < 1 || IDX_W < 1) begin : g_bad_slots
    $error("bad slot depth or index width");
  end

  // bus decode
  wire logic       acc      = psel && penable && ce;
  wire logic       wr_acc   = acc && pwrite;
  wire logic [7:0] a        = paddr;
  wire logic h_uop  = hit(a, rtts_pkg::OFF_UOP_SEL);
  wire logic h_exec = hit(a, rtts_pkg::OFF_EXEC_SEL);
  wire logic h_mov  = hit(a, rtts_pkg::OFF_MOVES_SEL);
  wire logic h_sen  = hit(a, rtts_pkg::OFF_SAMPLE_EN);
  wire logic h_mat  = hit(a, rtts_pkg::OFF_MATRIX_SEL);
  wire logic h_x1   = hit(a, rtts_pkg::OFF_XLATE_ONE);
  wire logic h_x0   = hit(a, rtts_pkg::OFF_XLATE_ZERO);
  wire logic h_mob  = hit(a, rtts_pkg::OFF_MOB_SEL);
  wire logic h_ret  = hit(a, rtts_pkg::OFF_RETIRE_SEL);
  wire logic h_cf   = hit(a, rtts_pkg::OFF_CNT_FRONT);
  wire logic h_ce   = hit(a, rtts_pkg::OFF_CNT_EXEC);
  wire logic h_cr   = hit(a, rtts_pkg::OFF_CNT_REPLAY);
  wire logic mapped = h_uop | h_exec | h_mov | h_sen | h_mat | h_x1 | h_x0 |
                      h_mob | h_ret | h_cf | h_ce | h_cr;

  assign pready  = ce;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= rtts_pkg::RESET_VAL;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= h_uop ? uop_sel_q : h_exec ? exec_sel_q :
                h_mov ? moves_sel_q : h_sen ? sample_en_q :
                h_mat ? matrix_q : h_x1 ? xlate_one_q :
                h_x0 ? xlate_zero_q : h_mob ? mob_sel_q :
                h_ret ? retire_sel_q : h_cf ? cnt_q[0] :
                h_ce ? cnt_q[1] : h_cr ? cnt_q[2] : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uop_sel_q    <= rtts_pkg::RESET_VAL;
      exec_sel_q   <= rtts_pkg::RESET_VAL;
      moves_sel_q  <= rtts_pkg::RESET_VAL;
      sample_en_q  <= rtts_pkg::RESET_VAL;
      matrix_q     <= rtts_pkg::RESET_VAL;
      xlate_one_q  <= rtts_pkg::RESET_VAL;
      xlate_zero_q <= rtts_pkg::RESET_VAL;
      mob_sel_q    <= rtts_pkg::RESET_VAL;
      retire_sel_q <= rtts_pkg::RESET_VAL;
    end else if (wr_acc) begin
      if (h_uop)  uop_sel_q    <= pwdata;
      if (h_exec) exec_sel_q   <= pwdata;
      if (h_mov)  moves_sel_q  <= pwdata;
      if (h_sen)  sample_en_q  <= pwdata;
      if (h_mat)  matrix_q     <= pwdata;
      if (h_x1)   xlate_one_q  <= pwdata;
      if (h_x0)   xlate_zero_q <= pwdata;
      if (h_mob)  mob_sel_q    <= pwdata;
      if (h_ret)  retire_sel_q <= pwdata;
    end
  end

  // front-end tag
  wire logic front_tag = !fp_stack_fault && (
    (up_is_load  && uop_sel_q[rtts_pkg::B_MARK_LOAD]) ||
    (up_is_store && uop_sel_q[rtts_pkg::B_MARK_STORE]));

  // execution tag
  wire logic arith_cls = (up_class != rtts_pkg::CLS_NONE) &&
                         (up_class != rtts_pkg::CLS_MOVES);
  wire logic exec_arm = exec_sel_q[rtts_pkg::B_ALL_OPS] &&
    exec_sel_q[rtts_pkg::B_TAG_OP] &&
    exec_sel_q[rtts_pkg::TAG_VAL_HI:rtts_pkg::TAG_VAL_LO] ==
      rtts_pkg::TAG_VAL_MATCH;
  wire logic moves_arm = moves_sel_q[rtts_pkg::B_PORT_ZERO] &&
    moves_sel_q[rtts_pkg::B_PORT_TWO] &&
    moves_sel_q[rtts_pkg::B_TAG_OP] &&
    moves_sel_q[rtts_pkg::TAG_VAL_HI:rtts_pkg::TAG_VAL_LO] ==
      rtts_pkg::TAG_VAL_MATCH;
  wire logic exec_tag = (arith_cls && exec_arm) ||
    (up_class == rtts_pkg::CLS_MOVES && moves_arm);

  // replay tag
  wire logic mob_arm = mob_sel_q[rtts_pkg::B_PARTIAL_FWD] &&
                       mob_sel_q[rtts_pkg::B_MISALIGNED_FWD];
  wire logic split_load_mask = up_is_load && xlate_one_q[rtts_pkg::B_SPLIT_MASK] &&
    xlate_one_q[rtts_pkg::EVSEL_HI:rtts_pkg::EVSEL_LO] ==
      rtts_pkg::EV_LOAD_PORT_REPLAY;
  wire logic split_store_mask = up_is_store &&
    xlate_zero_q[rtts_pkg::B_SPLIT_MASK] &&
    xlate_zero_q[rtts_pkg::EVSEL_HI:rtts_pkg::EVSEL_LO] ==
      rtts_pkg::EV_STORE_PORT_REPLAY;
  wire logic metric_hit =
    (sample_en_q[rtts_pkg::S_L1_MISS] && up_l1_miss) ||
    (sample_en_q[rtts_pkg::S_L2_MISS] && up_l2_fast_miss) ||
    (sample_en_q[rtts_pkg::S_DTLB] && up_dtlb_miss) ||
    (sample_en_q[rtts_pkg::S_MOB] && mob_arm && up_fwd_not_subset) ||
    (sample_en_q[rtts_pkg::S_SPLIT] && up_split && (split_load_mask || split_store_mask)) ||
    (sample_en_q[rtts_pkg::S_MISPRA] && sample_en_q[rtts_pkg::S_MISPRB] &&
     up_mispred);
  wire logic matrix_hit = (matrix_q[rtts_pkg::M_LOADS] && up_is_load) ||
    (matrix_q[rtts_pkg::M_STORES] && up_is_store) ||
    (matrix_q[rtts_pkg::M_BRANCHES] && up_is_branch);
  wire logic replay_tag = sample_en_q[rtts_pkg::S_ENA] &&
    sample_en_q[rtts_pkg::S_ENB] && metric_hit && matrix_hit;

  wire logic [2:0] new_tags = up_untaggable ? 3'h0 :
    {replay_tag, exec_tag, front_tag};
  wire logic [2:0] ret_tags;

  rtts_tag_store #(
    .DEPTH (DEPTH),
    .WIDTH (rtts_pkg::NUM_PATHS),
    .IDX_W (IDX_W)
  ) u_tags (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .wr_en   (up_valid),
    .wr_idx  (up_idx),
    .wr_tags (new_tags),
    .rd_en   (ret_valid),
    .rd_idx  (ret_idx),
    .rd_tags (ret_tags)
  );

  wire logic [2:0] bump = (ret_valid && !ret_bogus) ?
    (ret_tags & retire_sel_q[2:0]) : 3'h0;
  wire logic [2:0] clr  = wr_acc ? {h_cr, h_ce, h_cf} : 3'h0;

  for (genvar p = 0; p < rtts_pkg::NUM_PATHS; p++) begin : g_cnt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q[p] <= rtts_pkg::RESET_VAL;
      end else if (ce && bump[p]) begin
        cnt_q[p] <= clr[p] ? 32'h0000_0001 : cnt_q[p] + 32'h0000_0001;
      end else if (ce && clr[p]) begin
        cnt_q[p] <= 32'h0000_0000;
      end
    end
  end

  // assertions
  a_untag_silent: assert property (
    @(posedge pclk) disable iff (!presetn)
    up_valid && up_untaggable && ce && !(ret_valid && ret_idx == up_idx)
    |=> ret_tags == 3'h0 || ret_idx != $past(up_idx))
    else $error("untaggable operation kept a tag");
  a_fault_no_front: assert property (
    @(posedge pclk) disable iff (!presetn)
    fp_stack_fault |-> !new_tags[0])
    else $error("front tag set during stack fault");
  a_l2_fast_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    new_tags[2] && !up_l1_miss && !up_dtlb_miss && !up_split &&
    !up_fwd_not_subset && !up_mispred |-> up_l2_fast_miss)
    else $error("replay tag without a cause");
  a_mob_subset: assert property (
    @(posedge pclk) disable iff (!presetn)
    new_tags[2] && sample_en_q == 32'h0300_0200 |->
      up_fwd_not_subset && mob_arm)
    else $error("ordering replay tagged without cause");
  a_count_bogus: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && ret_valid && ret_bogus && !(wr_acc && (h_cf | h_ce | h_cr))
    |=> $stable(cnt_q[0]) && $stable(cnt_q[1]) && $stable(cnt_q[2]))
    else $error("bogus retirement counted");
  a_count_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && bump[0] && !clr[0] |=> cnt_q[0] == $past(cnt_q[0]) + 32'h0000_0001)
    else $error("front count did not step by one");
endmodule : rtts_retire_tagging
`default_nettype wire

// file: hw/rtts_pkg.sv
`default_nettype none
package rtts_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_UOP_SEL    = 8'h00;
  localparam logic [7:0] OFF_EXEC_SEL   = 8'h04;
  localparam logic [7:0] OFF_MOVES_SEL  = 8'h08;
  localparam logic [7:0] OFF_SAMPLE_EN  = 8'h0C;
  localparam logic [7:0] OFF_MATRIX_SEL = 8'h10;
  localparam logic [7:0] OFF_XLATE_ONE  = 8'h14;
  localparam logic [7:0] OFF_XLATE_ZERO = 8'h18;
  localparam logic [7:0] OFF_MOB_SEL    = 8'h1C;
  localparam logic [7:0] OFF_RETIRE_SEL = 8'h20;
  localparam logic [7:0] OFF_CNT_FRONT  = 8'h24;
  localparam logic [7:0] OFF_CNT_EXEC   = 8'h28;
  localparam logic [7:0] OFF_CNT_REPLAY = 8'h2C;
  // event mask field sits in bits 24:9; mask bit n is register bit 9+n
  localparam int MASK_BASE        = 9;
  localparam int B_MARK_LOAD      = MASK_BASE + 1;
  localparam int B_MARK_STORE     = MASK_BASE + 2;
  localparam int B_ALL_OPS        = MASK_BASE + 15;
  localparam int B_PORT_ZERO      = MASK_BASE + 3;
  localparam int B_PORT_TWO       = MASK_BASE + 4;
  localparam int B_PARTIAL_FWD    = MASK_BASE + 4;
  localparam int B_MISALIGNED_FWD = MASK_BASE + 5;
  localparam int B_SPLIT_MASK     = MASK_BASE + 1;
  localparam int B_TAG_OP         = 4;
  localparam int TAG_VAL_LO       = 5;
  localparam int TAG_VAL_HI       = 8;
  localparam logic [3:0] TAG_VAL_MATCH = 4'h1;
  localparam int EVSEL_LO         = 25;
  localparam int EVSEL_HI         = 31;
  // event codes for the two port replay events (plain values)
  localparam logic [6:0] EV_LOAD_PORT_REPLAY  = 7'h04;
  localparam logic [6:0] EV_STORE_PORT_REPLAY = 7'h05;
  // sampling enable bits
  localparam int S_L1_MISS  = 0;
  localparam int S_L2_MISS  = 1;
  localparam int S_DTLB     = 2;
  localparam int S_MOB      = 9;
  localparam int S_SPLIT    = 10;
  localparam int S_MISPRA   = 15;
  localparam int S_MISPRB   = 16;
  localparam int S_ENA      = 24;
  localparam int S_ENB      = 25;
  // matrix bits
  localparam int M_LOADS    = 0;
  localparam int M_STORES   = 1;
  localparam int M_BRANCHES = 4;
  // retire select: count enable per path; bogus retirements never count
  localparam int R_FRONT    = 0;
  localparam int R_EXEC     = 1;
  localparam int R_REPLAY   = 2;
  localparam int NUM_PATHS  = 3;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  // operation classes for execution tagging
  typedef enum logic [2:0] {
    CLS_NONE, CLS_PACKED_SP, CLS_PACKED_DP, CLS_SCALAR_SP,
    CLS_SCALAR_DP, CLS_SIMD128, CLS_X87_FP, CLS_MOVES
  } rtts_class_t;
endpackage : rtts_pkg
`default_nettype wire

// file: hw/rtts_tag_store.sv
`timescale 1ns/1ps
`default_nettype none
module rtts_tag_store #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 3,
  parameter int IDX_W = 4
) (
  // clock, reset and enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // tag write
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [WIDTH-1:0] wr_tags,
  // tag read at retirement, entry is freed
  input  wire logic             rd_en,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [WIDTH-1:0] rd_tags
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // refuse a depth that the index cannot address
  if (DEPTH > (1 << IDX_W) || DEPTH < 1) begin : g_bad_depth
    $error("bad tag store depth");
  end

  assign rd_tags = mem_q[rd_idx];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    wire logic hit_wr = wr_en && (wr_idx == IDX_W'(i));
    wire logic hit_rd = rd_en && (rd_idx == IDX_W'(i));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_q[i] <= '0;
      end else if (ce && hit_wr) begin
        mem_q[i] <= wr_tags;
      end else if (ce && hit_rd) begin
        mem_q[i] <= '0;
      end
    end
  end
endmodule : rtts_tag_store
`default_nettype wire

// file: testbench/rtts_retire_tagging_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rtts_retire_tagging_tb_top;
  localparam logic [7:0] CF = rtts_pkg::OFF_CNT_FRONT;
  localparam logic [7:0] CX = rtts_pkg::OFF_CNT_EXEC;
  localparam logic [7:0] CR = rtts_pkg::OFF_CNT_REPLAY;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        ce      = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        up_valid = 1'b0;
  logic [3:0]  up_idx   = 4'h0;
  logic [2:0]  up_kind  = 3'h0;
  logic [2:0]  up_class = 3'h0;
  logic        up_untag = 1'b0;
  logic [5:0]  up_cause = 6'h00;
  logic        fp_fault = 1'b0;
  logic        ret_valid = 1'b0;
  logic [3:0]  ret_idx   = 4'h0;
  logic        ret_bogus = 1'b0;
  int          failures  = 0;
  int          checks    = 0;
  int          cyc       = 0;

  rtts_retire_tagging rtts_retire_tagging_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .up_valid(up_valid), .up_idx(up_idx), .up_is_load(up_kind[0]),
    .up_is_store(up_kind[1]), .up_is_branch(up_kind[2]),
    .up_class(up_class), .up_untaggable(up_untag),
    .up_l1_miss(up_cause[0]), .up_l2_fast_miss(up_cause[1]),
    .up_dtlb_miss(up_cause[2]), .up_split(up_cause[3]),
    .up_fwd_not_subset(up_cause[4]), .up_mispred(up_cause[5]),
    .fp_stack_fault(fp_fault), .ret_valid(ret_valid), .ret_idx(ret_idx),
    .ret_bogus(ret_bogus)
  );

  always #50 pclk = ~pclk;

  task automatic conclude;
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      conclude();
    end
  end

  task automatic cmp(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  // read a counter, compare, then clear it by writing its offset
  task automatic cnt(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    cmp($sformatf("counter %h", a), x, r);
    wr(a, 32'h0);
  endtask : cnt

  // tag one operation, retire it on the next edge
  task automatic op(input logic [3:0] i, input logic [2:0] k,
                    input logic [2:0] c, input logic u,
                    input logic [5:0] z, input logic b);
    @(posedge pclk);
    up_valid <= 1'b1;
    up_idx <= i;
    up_kind <= k;
    up_class <= c;
    up_untag <= u;
    up_cause <= z;
    @(posedge pclk);
    up_valid <= 1'b0;
    ret_valid <= 1'b1;
    ret_idx <= i;
    ret_bogus <= b;
    @(posedge pclk);
    ret_valid <= 1'b0;
  endtask : op

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    cnt(CF, 32'h0);
    cnt(CX, 32'h0);
    cnt(CR, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    cmp("unmapped error", 32'h1, {31'h0, e});
    cmp("unmapped data", 32'h0, r);
  endtask : t_reset

  task automatic t_front;
    wr(rtts_pkg::OFF_RETIRE_SEL, 32'h0000_0007);
    wr(rtts_pkg::OFF_UOP_SEL, 32'h0000_0C00);
    op(4'h3, 3'b001, 3'h0, 1'b0, 6'h00, 1'b0);
    cnt(CF, 32'h1);
    op(4'h4, 3'b010, 3'h0, 1'b0, 6'h00, 1'b0);
    cnt(CF, 32'h1);
    op(4'h5, 3'b001, 3'h0, 1'b0, 6'h00, 1'b1);
    cnt(CF, 32'h0);
    op(4'h6, 3'b001, 3'h0, 1'b1, 6'h00, 1'b0);
    cnt(CF, 32'h0);
    fp_fault <= 1'b1;
    op(4'h7, 3'b001, 3'h0, 1'b0, 6'h00, 1'b0);
    fp_fault <= 1'b0;
    cnt(CF, 32'h0);
    // enable low: tagging and retirement are frozen
    ce <= 1'b0;
    op(4'h8, 3'b001, 3'h0, 1'b0, 6'h00, 1'b0);
    ce <= 1'b1;
    cnt(CF, 32'h0);
  endtask : t_front

  task automatic t_exec;
    wr(rtts_pkg::OFF_EXEC_SEL, 32'h0100_0030);
    for (int c = 1; c < 7; c++) begin
      op(4'(c), 3'b000, 3'(c), 1'b0, 6'h00, 1'b0);
      cnt(CX, 32'h1);
    end
    wr(rtts_pkg::OFF_EXEC_SEL, 32'h0100_0050);
    op(4'h8, 3'b000, 3'h1, 1'b0, 6'h00, 1'b0);
    cnt(CX, 32'h0);
    wr(rtts_pkg::OFF_MOVES_SEL, 32'h0000_3030);
    op(4'h9, 3'b001, 3'h7, 1'b0, 6'h00, 1'b0);
    cnt(CX, 32'h1);
    wr(rtts_pkg::OFF_MOVES_SEL, 32'h0000_1030);
    op(4'hA, 3'b001, 3'h7, 1'b0, 6'h00, 1'b0);
    cnt(CX, 32'h0);
  endtask : t_exec

  task automatic rp(input logic [31:0] s, input logic [31:0] m,
                    input logic [2:0] k, input logic [5:0] z,
                    input logic [31:0] x);
    wr(rtts_pkg::OFF_SAMPLE_EN, s);
    wr(rtts_pkg::OFF_MATRIX_SEL, m);
    op(4'hC, k, 3'h0, 1'b0, z, 1'b0);
    cnt(CR, x);
  endtask : rp

  task automatic t_replay;
    wr(rtts_pkg::OFF_XLATE_ONE, 32'h0800_0400);
    wr(rtts_pkg::OFF_XLATE_ZERO, 32'h0A00_0400);
    wr(rtts_pkg::OFF_MOB_SEL, 32'h0000_6000);
    rp(32'h0300_0001, 32'h1, 3'b001, 6'h01, 32'h1);
    rp(32'h0200_0001, 32'h1, 3'b001, 6'h01, 32'h0);
    rp(32'h0300_0002, 32'h1, 3'b001, 6'h02, 32'h1);
    rp(32'h0300_0002, 32'h1, 3'b001, 6'h01, 32'h0);
    rp(32'h0300_0004, 32'h2, 3'b010, 6'h04, 32'h1);
    rp(32'h0301_8000, 32'h10, 3'b100, 6'h20, 32'h1);
    rp(32'h0300_0200, 32'h1, 3'b001, 6'h10, 32'h1);
    rp(32'h0300_0200, 32'h1, 3'b001, 6'h00, 32'h0);
    rp(32'h0300_0400, 32'h1, 3'b001, 6'h08, 32'h1);
    rp(32'h0300_0400, 32'h2, 3'b010, 6'h08, 32'h1);
  endtask : t_replay

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_front();
    t_exec();
    t_replay();
    conclude();
  end
endmodule : rtts_retire_tagging_tb_top
`default_nettype wire
